// >>> logic/odcfg_pkg.sv
// constants for the output driver configuration register bank
// assumes byte-wide registers reached through the serial port's internal register strobes
package odcfg_pkg;
  localparam int DRV_CNT = 12;
  localparam int CH_CNT = 4;
  localparam int FRAC_IDX = 10;
  localparam int AUX_IDX = 11;
  // channel index 4 marks a driver that no shared channel power-down covers
  localparam int NO_CH = 4;

  // bank_a_driver0..2, bank_b_driver0..2, bank_c_driver0..1, bank_d_driver0..1, fractional, aux
  localparam logic [7:0] DRV_ADDR [DRV_CNT] = '{8'h28, 8'h29, 8'h2a, 8'h30, 8'h31, 8'h32,
                                               8'h38, 8'h39, 8'h40, 8'h41, 8'h48, 8'h4b};
  localparam int DRV_CH [DRV_CNT] = '{0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 4, 4};
  // channel power-down registers of channels a..d
  localparam logic [7:0] CH_ADDR [CH_CNT] = '{8'h26, 8'h2e, 8'h36, 8'h3e};

  localparam int PWR_BIT = 7;
  localparam int FMT_HI = 5;
  localparam int FMT_LO = 4;
  localparam int AMP_HI = 3;
  localparam int AMP_LO = 2;
  localparam int CH_PD_BIT = 7;

  localparam logic PWR_RST = 1'h0;
  localparam logic CH_PD_RST = 1'h0;
  localparam logic [1:0] MAIN_FMT_RST = 2'h0;
  localparam logic [1:0] AUX_FMT_RST = 2'h2;
  localparam logic [1:0] MAIN_AMP_RST = 2'h1;
  localparam logic [1:0] AUX_AMP_RST = 2'h0;

  localparam logic [1:0] AUX_FMT_LVDS = 2'h0;
  localparam logic [1:0] AUX_FMT_LVPECL = 2'h1;

  localparam logic [9:0] SWING_00_MV = 10'h15e;
  localparam logic [9:0] SWING_01_MV = 10'h1f4;
  localparam logic [9:0] SWING_10_MV = 10'h2bc;
  localparam logic [9:0] SWING_11_MV = 10'h352;
endpackage

// >>> logic/odcfg_driver.sv
// decode of one output driver's stored fields into analog control levels
// assumes fields come straight from the register bank flops
`timescale 1ns/100ps
module odcfg_driver #(
  parameter bit IS_AUX = 1'b0,
  parameter bit IS_FRAC = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_pwr_bit,
  input wire logic [1:0] i_fmt,
  input wire logic [1:0] i_amp,
  input wire logic i_chan_pd,
  output logic o_power_on,
  output logic o_lvpecl,
  output logic o_lvcmos,
  output logic [1:0] o_amp,
  output logic [9:0] o_swing_mv
);
  logic power_nxt;
  logic lvpecl_nxt;
  logic lvcmos_nxt;
  logic [9:0] swing_nxt;

  always_comb
  begin
    if (IS_FRAC)
      power_nxt = i_pwr_bit; // RULE3
    else if (IS_AUX)
      power_nxt = !i_pwr_bit; // RULE2
    else
      power_nxt = !i_pwr_bit && !i_chan_pd; // RULE1 RULE11
    if (IS_AUX)
    begin
      lvpecl_nxt = (i_fmt == odcfg_pkg::AUX_FMT_LVPECL); // RULE8
      lvcmos_nxt = i_fmt[1]; // RULE9
    end
    else
    begin
      lvpecl_nxt = i_fmt[0]; // RULE7
      lvcmos_nxt = 1'b0;
    end
    // format bits take no part in the swing choice
    case (i_amp) // RULE5 RULE6
      2'h0: swing_nxt = odcfg_pkg::SWING_00_MV;
      2'h1: swing_nxt = odcfg_pkg::SWING_01_MV;
      2'h2: swing_nxt = odcfg_pkg::SWING_10_MV;
      default: swing_nxt = odcfg_pkg::SWING_11_MV;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_power_on <= 1'b0;
      o_lvpecl <= 1'b0;
      o_lvcmos <= 1'b0;
      o_amp <= 2'h0;
      o_swing_mv <= 10'h000;
    end
    else
    begin
      o_power_on <= power_nxt;
      o_lvpecl <= lvpecl_nxt;
      o_lvcmos <= lvcmos_nxt;
      o_amp <= i_amp;
      o_swing_mv <= swing_nxt;
    end
  end
endmodule

// >>> logic/odcfg_regs.sv
// output driver configuration register bank: power, format and amplitude per clock output
// assumes the serial port core presents decoded byte writes and reads on i_clock
//
// Overview of operation
// RULE1 - a main output powers down while its power-down bit is 1 and stays powered while it is 0.
// RULE2 - the auxiliary output powers down while its power-down bit is 1 and stays powered while it is 0.
// RULE3 - the fractional output's power bit enables it at 1 and at 0 powers down it and its whole channel.
// RULE4 - the fractional power-enable bit resets to 0, so that output and channel start powered down.
// RULE5 - amplitude code 00, 01, 10, 11 selects 350, 500, 700 and 850 mV swing.
// RULE6 - the amplitude code means the same swing for LVDS and LVPECL formats.
// RULE7 - on main and fractional outputs format bit 0 selects LVDS and 1 selects LVPECL.
// RULE8 - the auxiliary two-bit format selects LVDS at 00 and LVPECL at 01.
// RULE9 - auxiliary format 1x makes both pins complementary single-ended 1.8V LVCMOS drivers.
// RULE10 - power sits at bit 7, format at bit 4 (5:4 on aux), amplitude at 3:2, reserved bits read zero.
// RULE11 - a channel power-down bit at 1 powers down the whole channel feeding its outputs, 0 keeps it on.
`timescale 1ns/100ps
module odcfg_regs (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output logic [11:0] o_drv_power_on,
  output logic [11:0] o_drv_lvpecl,
  output logic o_aux_lvcmos,
  output logic [11:0][1:0] o_drv_amp,
  output logic [11:0][9:0] o_drv_swing_mv,
  output logic [3:0] o_chan_power_on,
  output logic o_frac_chan_power_on
);
  logic pwr_r [odcfg_pkg::DRV_CNT];
  logic [1:0] fmt_r [odcfg_pkg::DRV_CNT];
  logic [1:0] amp_r [odcfg_pkg::DRV_CNT];
  logic [3:0] ch_pd_r;
  logic [7:0] rdata_nxt;
  logic [11:0] drv_lvcmos;

  genvar g;
  generate
    for (g = 0; g < odcfg_pkg::DRV_CNT; g = g + 1)
    begin : g_drv
      localparam bit IS_AUX = (g == odcfg_pkg::AUX_IDX);
      localparam bit IS_FRAC = (g == odcfg_pkg::FRAC_IDX);
      logic chan_pd;

      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          pwr_r[g] <= odcfg_pkg::PWR_RST; // RULE4
          fmt_r[g] <= IS_AUX ? odcfg_pkg::AUX_FMT_RST : odcfg_pkg::MAIN_FMT_RST;
          amp_r[g] <= IS_AUX ? odcfg_pkg::AUX_AMP_RST : odcfg_pkg::MAIN_AMP_RST;
        end
        else if (i_wr_en && i_addr == odcfg_pkg::DRV_ADDR[g])
        begin
          pwr_r[g] <= i_wdata[odcfg_pkg::PWR_BIT]; // RULE10
          // only the aux output keeps a second format bit
          fmt_r[g] <= {IS_AUX && i_wdata[odcfg_pkg::FMT_HI], i_wdata[odcfg_pkg::FMT_LO]}; // RULE10
          amp_r[g] <= i_wdata[odcfg_pkg::AMP_HI:odcfg_pkg::AMP_LO]; // RULE10
        end
      end

      if (odcfg_pkg::DRV_CH[g] == odcfg_pkg::NO_CH)
      begin : g_nochan
        assign chan_pd = 1'b0;
      end
      else
      begin : g_chan
        assign chan_pd = ch_pd_r[odcfg_pkg::DRV_CH[g]]; // RULE11
      end

      odcfg_driver #(
        .IS_AUX(IS_AUX),
        .IS_FRAC(IS_FRAC)
      ) u_drv (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_pwr_bit(pwr_r[g]),
        .i_fmt(fmt_r[g]),
        .i_amp(amp_r[g]),
        .i_chan_pd(chan_pd),
        .o_power_on(o_drv_power_on[g]),
        .o_lvpecl(o_drv_lvpecl[g]),
        .o_lvcmos(drv_lvcmos[g]),
        .o_amp(o_drv_amp[g]),
        .o_swing_mv(o_drv_swing_mv[g])
      );
    end

    for (g = 0; g < odcfg_pkg::CH_CNT; g = g + 1)
    begin : g_ch
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
          ch_pd_r[g] <= odcfg_pkg::CH_PD_RST;
        else if (i_wr_en && i_addr == odcfg_pkg::CH_ADDR[g])
          ch_pd_r[g] <= i_wdata[odcfg_pkg::CH_PD_BIT]; // RULE11
      end
    end
  endgenerate

  assign o_aux_lvcmos = drv_lvcmos[odcfg_pkg::AUX_IDX];

  // channel and fractional-channel power follow their control flops through one register stage, a clock later
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_chan_power_on <= 4'h0;
      o_frac_chan_power_on <= 1'b0;
    end
    else
    begin
      o_chan_power_on <= ~ch_pd_r; // RULE11
      o_frac_chan_power_on <= pwr_r[odcfg_pkg::FRAC_IDX]; // RULE3
    end
  end

  // unmapped addresses read zero, as do reserved bits
  always_comb
  begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < odcfg_pkg::DRV_CNT; i++)
    begin
      if (i_addr == odcfg_pkg::DRV_ADDR[i])
      begin
        rdata_nxt[odcfg_pkg::PWR_BIT] = pwr_r[i]; // RULE10
        rdata_nxt[odcfg_pkg::FMT_HI:odcfg_pkg::FMT_LO] = fmt_r[i];
        rdata_nxt[odcfg_pkg::AMP_HI:odcfg_pkg::AMP_LO] = amp_r[i];
      end
    end
    for (int i = 0; i < odcfg_pkg::CH_CNT; i++)
    begin
      if (i_addr == odcfg_pkg::CH_ADDR[i])
        rdata_nxt[odcfg_pkg::CH_PD_BIT] = ch_pd_r[i];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en)
        o_rdata <= rdata_nxt;
    end
  end
endmodule

// >>> test/odcfg_regs_asserts.sv
// port checks for the output driver bank
// assumes one clock and the byte strobe port
`timescale 1ns/100ps
module odcfg_regs_asserts (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rd_valid,
  input wire logic [11:0] o_drv_power_on,
  input wire logic [11:0] o_drv_lvpecl,
  input wire logic o_aux_lvcmos,
  input wire logic [11:0][1:0] o_drv_amp,
  input wire logic [11:0][9:0] o_drv_swing_mv,
  input wire logic [3:0] o_chan_power_on,
  input wire logic o_frac_chan_power_on
);
  localparam logic [9:0] SW [4] = '{odcfg_pkg::SWING_00_MV, odcfg_pkg::SWING_01_MV,
                                    odcfg_pkg::SWING_10_MV, odcfg_pkg::SWING_11_MV};
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // a second write to the same place would move the decode a cycle on
  property wr2(a, r);
    i_wr_en && i_addr == a ##1 !(i_wr_en && i_addr == a) |=> r;
  endproperty
  main_pwr_a: assert property (wr2(8'h28,
    o_drv_power_on[0] == (!$past(i_wdata[7], 2) && o_chan_power_on[0]))) else $error("main power");
  aux_pwr_a: assert property (wr2(8'h4b,
    o_drv_power_on[11] == !$past(i_wdata[7], 2))) else $error("aux power");
  frac_pwr_a: assert property (wr2(8'h48,
    o_drv_power_on[10] == $past(i_wdata[7], 2) && o_frac_chan_power_on == $past(i_wdata[7], 2)))
    else $error("frac power");
  amp_fmt_a: assert property (wr2(8'h30,
    o_drv_amp[3] == $past(i_wdata[3:2], 2) && o_drv_lvpecl[3] == $past(i_wdata[4], 2))) else $error("main fields");
  aux_fmt_a: assert property (wr2(8'h4b,
    o_aux_lvcmos == $past(i_wdata[5], 2) && o_drv_lvpecl[11] == ($past(i_wdata[5:4], 2) == 2'h1)))
    else $error("aux format");
  swing_map_a: assert property ($past(i_rst_n) |-> o_drv_swing_mv[3] == SW[o_drv_amp[3]])
    else $error("swing map");
  rd_rsvd_a: assert property (i_rd_en |=> o_rd_valid && o_rdata[6] == 1'b0 && o_rdata[1:0] == 2'h0)
    else $error("read port");
  chan_pd_a: assert property (wr2(8'h26,
    o_chan_power_on[0] == !$past(i_wdata[7], 2))) else $error("channel power");
  aux_mode_c: cover property (i_wr_en && i_addr == 8'h4b && i_wdata[5]);
  chan_pd_c: cover property (i_wr_en && i_addr == 8'h26 && i_wdata[7]);
  read_c: cover property (o_rd_valid);
endmodule
bind odcfg_regs odcfg_regs_asserts u_chk (.*);

// >>> test/testbench.sv
// directed bench for the output driver bank
// assumes only the byte strobe port reaches the registers
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("BAD %0t mismatch", $time); end end
module testbench;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic o_rd_valid, o_aux_lvcmos, o_frac_chan_power_on;
  logic [11:0] o_drv_power_on, o_drv_lvpecl;
  logic [11:0][1:0] o_drv_amp;
  logic [11:0][9:0] o_drv_swing_mv;
  logic [3:0] o_chan_power_on;
  logic [9:0] sw [4] = '{odcfg_pkg::SWING_00_MV, odcfg_pkg::SWING_01_MV, odcfg_pkg::SWING_10_MV, odcfg_pkg::SWING_11_MV};
  int fails = 0, check_count = 0, cycles = 0;
  always #2 i_clock = ~i_clock;
  odcfg_regs u_dut (.*);
  // returns once the decoded outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    {i_wr_en, i_addr, i_wdata} = {1'b1, a, d};
    @(negedge i_clock);
    i_wr_en = 1'b0;
    @(negedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clock);
    {i_rd_en, i_addr} = {1'b1, a};
    @(negedge i_clock);
    i_rd_en = 1'b0;
    // the valid pulse stands for one cycle only, so look before the next edge
    `CHK(o_rd_valid, 1'b1)
    `CHK(o_rdata, e)
    @(negedge i_clock);
    `CHK(o_rd_valid, 1'b0)
  endtask
  task automatic t_reset();
    `CHK(o_drv_power_on, 12'hbff)
    `CHK(o_frac_chan_power_on, 1'b0)
    `CHK(o_aux_lvcmos, 1'b1)
    `CHK(o_drv_swing_mv[0], sw[1])
    rd(8'h48, 8'h04);
    rd(8'h4b, 8'h20);
  endtask
  task automatic t_main();
    wr(8'h28, 8'hff);
    `CHK(o_drv_power_on[0], 1'b0)
    rd(8'h28, 8'h9c);
    wr(8'h28, 8'h00);
    `CHK(o_drv_power_on[0], 1'b1)
  endtask
  // the format bit rides along so each code is seen in both formats
  task automatic t_amp();
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h30, 8'(c << 2));
      `CHK(o_drv_swing_mv[3], sw[c % 4])
      `CHK(o_drv_amp[3], 2'(c))
      `CHK(o_drv_lvpecl[3], c[2])
    end
  endtask
  task automatic t_frac();
    wr(8'h48, 8'h80);
    `CHK({o_drv_power_on[10], o_frac_chan_power_on}, 2'h3)
    wr(8'h48, 8'h10);
    `CHK({o_drv_power_on[10], o_frac_chan_power_on}, 2'h0)
    `CHK(o_drv_lvpecl[10], 1'b1)
  endtask
  task automatic t_aux();
    for (int f = 0; f < 4; f++)
    begin
      wr(8'h4b, 8'h80 | 8'(f << 4));
      `CHK(o_drv_power_on[11], 1'b0)
      `CHK(o_drv_lvpecl[11], f == 1)
      `CHK(o_aux_lvcmos, f[1])
    end
    wr(8'h4b, 8'h7f);
    rd(8'h4b, 8'h3c);
    `CHK(o_drv_power_on[11], 1'b1)
  endtask
  task automatic t_chan();
    wr(8'h26, 8'h80);
    `CHK(o_chan_power_on, 4'he)
    `CHK(o_drv_power_on[1], 1'b0)
    wr(8'h27, 8'hff);
    rd(8'h27, 8'h00);
    wr(8'h26, 8'h00);
    `CHK(o_chan_power_on, 4'hf)
  endtask
  // reset in mid-run must drop every power output and restore the stored defaults
  task automatic t_rerst();
    wr(8'h48, 8'h80);
    @(negedge i_clock);
    i_rst_n = 1'b0;
    @(negedge i_clock);
    `CHK({o_drv_power_on, o_chan_power_on, o_frac_chan_power_on}, 17'h00000)
    @(negedge i_clock);
    i_rst_n = 1'b1;
    @(negedge i_clock);
    `CHK(o_drv_power_on, 12'hbff)
    rd(8'h48, 8'h04);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_n = 1'b1;
    @(negedge i_clock);
    t_reset();
    t_main();
    t_amp();
    t_frac();
    t_aux();
    t_chan();
    t_rerst();
    conclude();
  end
endmodule
